// File: uart_baud_frame_ctrl.sv
// Baud generator, frame format control and pin routing of the serial port
`timescale 1ns/1ps
module uart_baud_frame_ctrl
    import uart_baud_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // System mode
    input wire logic cpu_wait,
    // Flags from the receiver
    input wire logic line_break_flag,
    input wire logic rx_edge_flag,
    input wire logic rx_start_bit,
    input wire logic rx_stop_bit,
    input wire logic rx_char_valid,
    input wire logic [8:0] rx_char,
    // Transmitter data path
    input wire logic tx_serial,
    input wire logic [8:0] tx_char_in,
    // Pins
    input wire logic rx_pin,
    input wire logic tx_pin_in,
    output logic tx_pin_out,
    output logic tx_pin_oe,
    output logic rx_pin_released,
    // To the data paths
    output logic baud_tick,
    output logic rx_serial,
    output logic receiver_enable,
    output logic transmitter_enable,
    output logic port_clock_run,
    output frame_cfg_t frame_cfg,
    output logic [8:0] tx_char_out,
    output logic parity_error,
    output logic idle_detect,
    output logic line_break_irq,
    output logic rx_edge_irq
);

    state_t st;
    state_t next_st;
    ahb_addr_t ap;
    logic [7:0] wbyte;
    logic loop_select;
    logic single_wire;
    logic bit_tick;
    logic [3:0] idle_need;

    // Xor of the data bits below the parity position
    function automatic logic data_xor(input logic [8:0] ch, input logic nine);
        logic r;
        r = ^ch[7:0];
        if (!nine)
        begin
            r = ^ch[6:0];
        end
        return r;
    endfunction

    function automatic logic [7:0] read_reg(input state_t s, input logic [7:0] a,
                                           input logic lbk, input logic rxe);
        logic [7:0] r;
        r = 8'h00;
        case (a)
            OFF_BAUD_HIGH:
            begin
                r[BIT_LBK_IE] = s.lbk_ie;
                r[BIT_RXE_IE] = s.rxe_ie;
                r[4:0] = s.div_hold;
            end
            OFF_BAUD_LOW: r = s.divisor[7:0];
            OFF_CONTROL_ONE: r = s.ctrl1;
            OFF_CONTROL_TWO:
            begin
                r[BIT_TX_DIR] = s.tx_dir;
                r[BIT_TE] = s.te;
                r[BIT_RE] = s.re;
            end
            OFF_STATUS:
            begin
                r[BIT_ST_LBK] = lbk;
                r[BIT_ST_RXE] = rxe;
                r[BIT_ST_ARMED] = s.armed;
            end
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    assign ap = '{sel: hsel, trans: htrans, write: hwrite, size: hsize, addr: haddr};
    assign wbyte = hwdata[7:0];
    assign loop_select = st.ctrl1[BIT_LOOP];
    assign single_wire = loop_select & st.ctrl1[BIT_RX_SOURCE];
    assign bit_tick = st.baud_tick & (st.os_cnt == OVERSAMPLE_LAST);
    assign idle_need = st.ctrl1[BIT_NINE] ? IDLE_BITS_NINE : IDLE_BITS_EIGHT;

    always_comb
    begin
        next_st = st;
        next_st.hreadyout = 1'b1;

        // Pin synchronisers
        next_st.rxp_s1 = rx_pin;
        next_st.rxp_s2 = st.rxp_s1;
        next_st.txp_s1 = tx_pin_in;
        next_st.txp_s2 = st.txp_s1;

        // Data phase of a write: the bus never waits, so hready is high here
        next_st.dp_write = 1'b0;
        if (st.dp_write)
        begin
            case (st.dp_addr)
                OFF_BAUD_HIGH:
                begin
                    next_st.lbk_ie = wbyte[BIT_LBK_IE];
                    next_st.rxe_ie = wbyte[BIT_RXE_IE];
                    next_st.div_hold = wbyte[4:0];
                end
                OFF_BAUD_LOW:
                begin
                    next_st.divisor = {st.div_hold, wbyte};
                end
                OFF_CONTROL_ONE: next_st.ctrl1 = wbyte;
                OFF_CONTROL_TWO:
                begin
                    next_st.tx_dir = wbyte[BIT_TX_DIR];
                    next_st.te = wbyte[BIT_TE];
                    next_st.re = wbyte[BIT_RE];
                    if (wbyte[BIT_TE] || wbyte[BIT_RE])
                    begin
                        next_st.armed = 1'b1;
                    end
                end
                default:
                begin
                end
            endcase
        end

        // Address phase; read data is taken from the updated copy so a read
        // right behind a write to the same register sees the new value
        if (ap.sel && hready && ap.trans == HTRANS_NONSEQ)
        begin
            next_st.dp_write = ap.write;
            next_st.dp_addr = ap.addr;
            if (!ap.write)
            begin
                next_st.hrdata = {24'h000000,
                                  read_reg(next_st, ap.addr, line_break_flag, rx_edge_flag)};
            end
        end

        // Wait mode gating of the port's own clocking
        next_st.clk_run = !(cpu_wait && st.ctrl1[BIT_WAIT_STOP]);

        // Baud generator
        next_st.baud_tick = 1'b0;
        if (!st.armed || st.divisor == '0)
        begin
            next_st.baud_cnt = '0;
            next_st.os_cnt = '0;
        end
        else if (st.clk_run)
        begin
            if (st.baud_cnt <= 13'h0001)
            begin
                next_st.baud_cnt = st.divisor;
                next_st.baud_tick = 1'b1;
            end
            else
            begin
                next_st.baud_cnt = st.baud_cnt - 13'h0001;
            end
        end
        if (st.baud_tick)
        begin
            next_st.os_cnt = st.os_cnt + 4'h1;
        end

        // Receiver input routing
        if (!loop_select)
        begin
            next_st.rx_serial = st.rxp_s2;
        end
        else if (single_wire)
        begin
            next_st.rx_serial = st.txp_s2;
        end
        else
        begin
            next_st.rx_serial = tx_serial;
        end

        // Transmit pin: in single-wire mode the direction bit turns the line around
        next_st.pins.tx_out = st.te ? tx_serial : 1'b1;
        next_st.pins.tx_oe = st.te && (!single_wire || st.tx_dir);
        next_st.pins.rx_released = !st.re || loop_select;

        // Interrupt requests
        next_st.lbk_irq = st.lbk_ie && line_break_flag;
        next_st.rxe_irq = st.rxe_ie && rx_edge_flag;

        // Idle-line detector
        next_st.idle_seen = 1'b0;
        if (!st.re)
        begin
            next_st.idle_run = 1'b0;
            next_st.idle_cnt = '0;
        end
        else if (st.clk_run)
        begin
            if ((rx_start_bit && !st.ctrl1[BIT_IDLE_TYPE]) ||
                (rx_stop_bit && st.ctrl1[BIT_IDLE_TYPE]))
            begin
                next_st.idle_run = 1'b1;
                next_st.idle_cnt = '0;
            end
            else if (st.idle_run && !st.rx_serial)
            begin
                next_st.idle_cnt = '0;
            end
            else if (st.idle_run && bit_tick)
            begin
                next_st.idle_cnt = st.idle_cnt + 4'h1;
                if (st.idle_cnt + 4'h1 == idle_need)
                begin
                    next_st.idle_seen = 1'b1;
                    next_st.idle_run = 1'b0;
                end
            end
        end

        // Parity generation on the outgoing character
        next_st.tx_char = tx_char_in;
        if (st.ctrl1[BIT_PAR_EN])
        begin
            if (st.ctrl1[BIT_NINE])
            begin
                next_st.tx_char[8] = data_xor(tx_char_in, 1'b1) ^
                                     st.ctrl1[BIT_PAR_TYPE];
            end
            else
            begin
                next_st.tx_char[7] = data_xor(tx_char_in, 1'b0) ^
                                     st.ctrl1[BIT_PAR_TYPE];
                next_st.tx_char[8] = 1'b0;
            end
        end
        else if (!st.ctrl1[BIT_NINE])
        begin
            next_st.tx_char[8] = 1'b0;
        end

        // Parity check on the incoming character
        next_st.parity_error = 1'b0;
        if (rx_char_valid && st.ctrl1[BIT_PAR_EN])
        begin
            if (st.ctrl1[BIT_NINE])
            begin
                next_st.parity_error = (data_xor(rx_char, 1'b1) ^ rx_char[8]) !=
                                       st.ctrl1[BIT_PAR_TYPE];
            end
            else
            begin
                next_st.parity_error = (data_xor(rx_char, 1'b0) ^ rx_char[7]) !=
                                       st.ctrl1[BIT_PAR_TYPE];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st <= '0;
            st.hreadyout <= 1'b1;
            st.div_hold <= RST_DIV_HIGH;
            st.divisor <= {RST_DIV_HIGH, RST_DIV_LOW};
            st.ctrl1 <= RST_CONTROL_ONE;
            st.rxp_s1 <= 1'b1;
            st.rxp_s2 <= 1'b1;
            st.txp_s1 <= 1'b1;
            st.txp_s2 <= 1'b1;
            st.rx_serial <= 1'b1;
            st.pins.tx_out <= 1'b1;
            st.pins.rx_released <= 1'b1;
            st.clk_run <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign hreadyout = st.hreadyout;
    assign hresp = 1'b0;
    assign hrdata = st.hrdata;
    assign tx_pin_out = st.pins.tx_out;
    assign tx_pin_oe = st.pins.tx_oe;
    assign rx_pin_released = st.pins.rx_released;
    assign baud_tick = st.baud_tick;
    assign rx_serial = st.rx_serial;
    assign receiver_enable = st.re;
    assign transmitter_enable = st.te;
    assign port_clock_run = st.clk_run;
    assign frame_cfg = '{nine_bit: st.ctrl1[BIT_NINE],
                         wake_address: st.ctrl1[BIT_WAKE],
                         idle_after_stop: st.ctrl1[BIT_IDLE_TYPE],
                         parity_enable: st.ctrl1[BIT_PAR_EN],
                         parity_odd: st.ctrl1[BIT_PAR_TYPE]};
    assign tx_char_out = st.tx_char;
    assign parity_error = st.parity_error;
    assign idle_detect = st.idle_seen;
    assign line_break_irq = st.lbk_irq;
    assign rx_edge_irq = st.rxe_irq;

endmodule

// File: uart_baud_pkg.sv
// Constants, register map and carrier types of the baud and frame control block
// Summary of operation
// - High divisor write is held in a buffer until the low half is written.
// - Baud generator stays idle after reset until receiver or transmitter enable written one.
// - High register bits 4:0 are divisor 12:8; low register holds divisor 7:0.
// - A zero divisor stops the baud generator; no ticks come out.
// - Divisor 1 to 8191 gives bit rate of bus clock over sixteen times divisor.
// - High register bit 7 turns the line break flag into an interrupt request.
// - High register bit 6 turns the receive edge flag into an interrupt request.
// - Loop select routes transmitter output to receiver with receiver source zero, the transmit pin with source one; receive pin is unused.
// - Wait-stop one freezes the port in wait mode; zero keeps it running.
// - Receiver source is ignored without loop select; zero means internal loopback.
// - Loop select with receiver source one is single-wire mode on the transmit pin.
// - Character length bit selects eight or nine data bits, LSB first, both directions.
// - Wakeup method bit picks idle-line wakeup at zero, address-mark at one.
// - Idle needs 10 or 11 high bit times, counted after start or stop bit.
// - Parity enable makes the top data bit a generated and checked parity bit.
// - Parity type zero is even, one is odd, counting all ones of the character.
// - Loop select releases the receive pin to general use even with receiver enabled.
// - Transmitter enable makes the port drive the transmit pin, in single-wire mode only with the direction bit set; enables switch halves on.
package uart_baud_pkg;

    localparam int DIV_W = 13;
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
    localparam logic [3:0] IDLE_BITS_EIGHT = 4'ha;
    localparam logic [3:0] IDLE_BITS_NINE = 4'hb;

    // Register byte offsets
    localparam logic [7:0] OFF_BAUD_HIGH = 8'h00;
    localparam logic [7:0] OFF_BAUD_LOW = 8'h04;
    localparam logic [7:0] OFF_CONTROL_ONE = 8'h08;
    localparam logic [7:0] OFF_CONTROL_TWO = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;

    // Reset values
    localparam logic [4:0] RST_DIV_HIGH = 5'h00;
    localparam logic [7:0] RST_DIV_LOW = 8'h04;
    localparam logic [7:0] RST_CONTROL_ONE = 8'h00;

    // Field positions
    localparam int BIT_LBK_IE = 7;
    localparam int BIT_RXE_IE = 6;
    localparam int BIT_LOOP = 7;
    localparam int BIT_WAIT_STOP = 6;
    localparam int BIT_RX_SOURCE = 5;
    localparam int BIT_NINE = 4;
    localparam int BIT_WAKE = 3;
    localparam int BIT_IDLE_TYPE = 2;
    localparam int BIT_PAR_EN = 1;
    localparam int BIT_PAR_TYPE = 0;
    localparam int BIT_TX_DIR = 5;
    localparam int BIT_TE = 3;
    localparam int BIT_RE = 2;
    localparam int BIT_ST_LBK = 7;
    localparam int BIT_ST_RXE = 6;
    localparam int BIT_ST_ARMED = 0;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic sel;
        logic [1:0] trans;
        logic write;
        logic [2:0] size;
        logic [7:0] addr;
    } ahb_addr_t;

    typedef struct packed {
        logic tx_out;
        logic tx_oe;
        logic rx_released;
    } pin_ctrl_t;

    typedef struct packed {
        logic nine_bit;
        logic wake_address;
        logic idle_after_stop;
        logic parity_enable;
        logic parity_odd;
    } frame_cfg_t;

    typedef struct packed {
        logic hreadyout;
        logic [31:0] hrdata;
        logic dp_write;
        logic [7:0] dp_addr;
        logic lbk_ie;
        logic rxe_ie;
        logic [4:0] div_hold;
        logic [12:0] divisor;
        logic [7:0] ctrl1;
        logic re;
        logic te;
        logic tx_dir;
        logic armed;
        logic [12:0] baud_cnt;
        logic baud_tick;
        logic [3:0] os_cnt;
        logic rxp_s1;
        logic rxp_s2;
        logic txp_s1;
        logic txp_s2;
        logic rx_serial;
        pin_ctrl_t pins;
        logic clk_run;
        logic lbk_irq;
        logic rxe_irq;
        logic idle_run;
        logic [3:0] idle_cnt;
        logic idle_seen;
        logic [8:0] tx_char;
        logic parity_error;
    } state_t;

endpackage

// File: serial_node_model.sv
// Remote serial node on the receive pin and on the shared transmit wire
`timescale 1ns/1ps
module serial_node_model
(
    // Device transmit pin
    input wire logic tx_pin_out,
    input wire logic tx_pin_oe,
    // Remote transmitter level
    input wire logic remote_level,
    // Lines seen by the device
    output logic rx_pin,
    output logic tx_line
);
    assign rx_pin = remote_level;
    // Remote backs off the shared wire while the device drives it
    assign tx_line = tx_pin_oe ? tx_pin_out : remote_level;
endmodule

// File: uart_baud_frame_ctrl_properties.sv
// Concurrent checks on the ports of the baud and frame control block
`timescale 1ns/1ps
module uart_baud_frame_ctrl_properties
    import uart_baud_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Read data and inputs watched
    input wire logic [31:0] hrdata,
    input wire logic cpu_wait,
    input wire logic line_break_flag,
    input wire logic rx_edge_flag,
    input wire logic rx_char_valid,
    input wire logic [8:0] tx_char_in,
    // Outputs watched
    input wire logic tx_pin_out,
    input wire logic tx_pin_oe,
    input wire logic rx_pin_released,
    input wire logic baud_tick,
    input wire logic receiver_enable,
    input wire logic transmitter_enable,
    input wire logic port_clock_run,
    input wire frame_cfg_t frame_cfg,
    input wire logic [8:0] tx_char_out,
    input wire logic parity_error,
    input wire logic line_break_irq,
    input wire logic rx_edge_irq
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_upper_zero: assert property (hrdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_break_irq_cause: assert property (line_break_irq |-> $past(line_break_flag))
        else $error("break request without flag");
    a_edge_irq_cause: assert property (rx_edge_irq |-> $past(rx_edge_flag))
        else $error("edge request without flag");
    a_freeze_no_tick: assert property (
        !port_clock_run && $past(!port_clock_run) |-> !baud_tick)
        else $error("tick while frozen");
    a_freeze_cause: assert property ($fell(port_clock_run) |-> $past(cpu_wait))
        else $error("freeze outside wait mode");
    // Config must be steady over the register stage or the check would race it
    a_parity_gen: assert property (
        $stable(frame_cfg) && $past(frame_cfg) == $past(frame_cfg, 2) &&
        frame_cfg.parity_enable |->
        ((frame_cfg.nine_bit ? ^tx_char_out : ^tx_char_out[7:0]) == frame_cfg.parity_odd) &&
        (frame_cfg.nine_bit || !tx_char_out[8]))
        else $error("bad generated parity");
    a_data_order: assert property (
        $stable(frame_cfg) && $past(frame_cfg) == $past(frame_cfg, 2) &&
        !frame_cfg.parity_enable |->
        tx_char_out == (frame_cfg.nine_bit ? $past(tx_char_in) :
                        {1'b0, $past(tx_char_in[7:0])}))
        else $error("character not passed through");
    a_perr_cause: assert property (parity_error |-> $past(rx_char_valid))
        else $error("parity error without character");
    a_tx_pin_idle: assert property (
        !transmitter_enable && $past(!transmitter_enable) |-> !tx_pin_oe && tx_pin_out)
        else $error("transmit pin driven while off");
    a_rx_pin_free: assert property (
        !receiver_enable && $past(!receiver_enable) |-> rx_pin_released)
        else $error("receive pin held while off");
endmodule

bind uart_baud_frame_ctrl uart_baud_frame_ctrl_properties chk (.hclk(hclk), .hresetn(hresetn),
    .hrdata(hrdata), .cpu_wait(cpu_wait), .line_break_flag(line_break_flag),
    .rx_edge_flag(rx_edge_flag), .rx_char_valid(rx_char_valid), .tx_char_in(tx_char_in),
    .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .rx_pin_released(rx_pin_released),
    .baud_tick(baud_tick), .receiver_enable(receiver_enable),
    .transmitter_enable(transmitter_enable), .port_clock_run(port_clock_run),
    .frame_cfg(frame_cfg), .tx_char_out(tx_char_out), .parity_error(parity_error),
    .line_break_irq(line_break_irq), .rx_edge_irq(rx_edge_irq));

// File: uart_baud_frame_ctrl_bench.sv
// Self-checking bench for the baud and frame control block
`timescale 1ns/1ps
module uart_baud_frame_ctrl_bench
    import uart_baud_pkg::*;
;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, cpu_wait = 0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata, q;
    logic line_break_flag = 0, rx_edge_flag = 0, rx_start_bit = 0, rx_stop_bit = 0;
    logic rx_char_valid = 0, tx_serial = 1, remote_level = 1;
    logic [8:0] rx_char = 9'h000, tx_char_in = 9'h000, tx_char_out;
    logic hreadyout, hresp, tx_pin_out, tx_pin_oe, rx_pin_released, baud_tick, rx_serial;
    logic receiver_enable, transmitter_enable, port_clock_run, parity_error, idle_detect;
    logic line_break_irq, rx_edge_irq, rx_pin, tx_pin_in;
    frame_cfg_t frame_cfg;
    logic [7:0] cf [6] = '{8'h00, 8'h10, 8'h02, 8'h03, 8'h12, 8'h13};
    logic [8:0] dv [4] = '{9'h000, 9'h1ff, 9'h0a5, 9'h12c};
    int miscompares = 0, cmp_count = 0, cyc = 0;

    // Only one slave on the bus, so its ready is the bus ready
    assign hready = hreadyout;

    always #10 hclk = ~hclk;

    uart_baud_frame_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cpu_wait(cpu_wait),
        .line_break_flag(line_break_flag), .rx_edge_flag(rx_edge_flag),
        .rx_start_bit(rx_start_bit), .rx_stop_bit(rx_stop_bit), .rx_char_valid(rx_char_valid),
        .rx_char(rx_char), .tx_serial(tx_serial), .tx_char_in(tx_char_in), .rx_pin(rx_pin),
        .tx_pin_in(tx_pin_in), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe),
        .rx_pin_released(rx_pin_released), .baud_tick(baud_tick), .rx_serial(rx_serial),
        .receiver_enable(receiver_enable), .transmitter_enable(transmitter_enable),
        .port_clock_run(port_clock_run), .frame_cfg(frame_cfg), .tx_char_out(tx_char_out),
        .parity_error(parity_error), .idle_detect(idle_detect),
        .line_break_irq(line_break_irq), .rx_edge_irq(rx_edge_irq));

    serial_node_model node (.tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe),
        .remote_level(remote_level), .rx_pin(rx_pin), .tx_line(tx_pin_in));

    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1)
            @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1)
            @(posedge hclk);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        bus(a, 1'b0, 32'h0);
        chk(what, exp, q);
        chk({what, "_resp"}, 32'h0, hresp);
    endtask

    // Settles first so a reload left over from the old divisor is not counted
    task automatic ticks(input int len, input int exp, input string what);
        int c = 0;
        repeat (260) @(posedge hclk);
        repeat (len)
        begin
            @(posedge hclk);
            if (baud_tick === 1'b1)
                c++;
        end
        chk(what, exp, c);
    endtask

    task automatic pins(input logic [7:0] c1, c2, input logic tx, rem, input logic [2:0] exp);
        wr(OFF_CONTROL_ONE, {24'h0, c1});
        wr(OFF_CONTROL_TWO, {24'h0, c2});
        tx_serial <= tx;
        remote_level <= rem;
        repeat (6) @(posedge hclk);
        chk("rx_rel_oe", exp, {rx_serial, rx_pin_released, tx_pin_oe});
        chk("enables", 2'h3, {receiver_enable, transmitter_enable});
    endtask

    task automatic idle(input logic stop, input int lo, input int hi);
        int c = 0;
        rx_stop_bit <= stop;
        rx_start_bit <= !stop;
        @(posedge hclk);
        rx_stop_bit <= 1'b0;
        rx_start_bit <= 1'b0;
        while (idle_detect !== 1'b1 && c < 400)
        begin
            @(posedge hclk);
            c++;
        end
        chk("idle_cycles", 1, c >= lo && c <= hi);
    endtask

    function automatic logic [8:0] par(input logic [7:0] c, input logic [8:0] d);
        if (!c[1])
            return c[4] ? d : {1'b0, d[7:0]};
        return c[4] ? {^d[7:0] ^ c[0], d[7:0]} : {1'b0, ^d[6:0] ^ c[0], d[6:0]};
    endfunction

    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            summarize();
        end
    end

    initial
    begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(OFF_BAUD_HIGH, 32'h00, "div_high");
        rd(OFF_BAUD_LOW, 32'h04, "div_low");
        rd(OFF_CONTROL_ONE, 32'h00, "ctrl1");
        wr(8'h14, 32'hff);
        rd(8'h14, 32'h00, "unmapped");
        ticks(40, 0, "ticks_unarmed");
        rd(OFF_STATUS, 32'h00, "status_unarmed");
        wr(OFF_CONTROL_TWO, 32'h08);
        rd(OFF_CONTROL_TWO, 32'h08, "ctrl2");
        rd(OFF_STATUS, 32'h01, "status_armed");
        ticks(64, 16, "ticks_div4");
        wr(OFF_BAUD_HIGH, 32'h01);
        rd(OFF_BAUD_HIGH, 32'h01, "div_high_buf");
        ticks(64, 16, "ticks_held");
        wr(OFF_BAUD_LOW, 32'h00);
        ticks(512, 2, "ticks_div256");
        wr(OFF_BAUD_HIGH, 32'h00);
        wr(OFF_BAUD_LOW, 32'h00);
        ticks(300, 0, "ticks_zero");
        wr(OFF_BAUD_LOW, 32'h01);
        ticks(32, 32, "ticks_div1");
        line_break_flag <= 1'b1;
        rx_edge_flag <= 1'b1;
        wr(OFF_BAUD_HIGH, 32'hc0);
        rd(OFF_BAUD_HIGH, 32'hc0, "irq_enables");
        chk("irq_both", 2'h3, {line_break_irq, rx_edge_irq});
        rd(OFF_STATUS, 32'hc1, "status_flags");
        wr(OFF_BAUD_HIGH, 32'h40);
        repeat (2) @(posedge hclk);
        chk("irq_edge_only", 2'h1, {line_break_irq, rx_edge_irq});
        wr(OFF_BAUD_HIGH, 32'h00);
        repeat (2) @(posedge hclk);
        chk("irq_none", 2'h0, {line_break_irq, rx_edge_irq});
        line_break_flag <= 1'b0;
        rx_edge_flag <= 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            wr(OFF_CONTROL_ONE, 32'h1 << i);
            @(posedge hclk);
            chk("frame_cfg", 32'h1 << i, frame_cfg);
        end
        for (int i = 0; i < 6; i++)
        begin
            wr(OFF_CONTROL_ONE, {24'h0, cf[i]});
            foreach (dv[j])
            begin
                tx_char_in <= dv[j];
                rx_char <= dv[j];
                rx_char_valid <= 1'b1;
                @(posedge hclk);
                rx_char_valid <= 1'b0;
                @(posedge hclk);
                chk("tx_char", par(cf[i], dv[j]), tx_char_out);
                chk("perr", cf[i][1] && ((cf[i][4] ? ^dv[j] : ^dv[j][7:0]) != cf[i][0]),
                    parity_error);
            end
        end
        pins(8'h00, 8'h0c, 1'b1, 1'b0, 3'b001);
        pins(8'h80, 8'h0c, 1'b1, 1'b0, 3'b111);
        pins(8'h80, 8'h0c, 1'b0, 1'b1, 3'b011);
        pins(8'ha0, 8'h0c, 1'b1, 1'b0, 3'b010);
        pins(8'ha0, 8'h2c, 1'b1, 1'b0, 3'b111);
        wr(OFF_CONTROL_ONE, 32'h00);
        cpu_wait <= 1'b1;
        repeat (4) @(posedge hclk);
        chk("clk_run", 1, port_clock_run);
        wr(OFF_CONTROL_ONE, 32'h40);
        ticks(32, 0, "ticks_frozen");
        chk("clk_frozen", 0, port_clock_run);
        cpu_wait <= 1'b0;
        ticks(32, 32, "ticks_resumed");
        wr(OFF_CONTROL_ONE, 32'h00);
        remote_level <= 1'b1;
        repeat (8) @(posedge hclk);
        idle(1'b0, 140, 166);
        wr(OFF_CONTROL_ONE, 32'h14);
        idle(1'b0, 400, 400);
        idle(1'b1, 156, 182);
        summarize();
    end
endmodule
